// ### common/mfs_consts.svh
// constants for the motor driver fault shutdown block
// What this block does
// - thermal trip forces both phase enables off
// - thermal latch holds until standby or power-up
// - overcurrent trip forces outputs off
// - overcurrent qualified over four oscillator cycles
// - leave overcurrent state within four cycles
// - overcurrent latch holds until standby or power-up
// - latched overcurrent behaves as standby
// - both mode pins low decode standby
// - overcurrent trip on either phase disables both phases
// - low supply forces both phase enables off
`ifndef MFS_CONSTS_SVH
`define MFS_CONSTS_SVH
// ================================================================
// timing counts, in chopper oscillator cycles
`define MFS_MASK_CYCLES 3'h4
`define MFS_EXIT_CYCLES 3'h4
// ================================================================
// mode select encodings {mode_1, mode_2}
`define MFS_MODE_STANDBY 2'h0
`define MFS_MODE_TWO 2'h1
`define MFS_MODE_ONE_TWO 2'h2
`define MFS_MODE_W_ONE_TWO 2'h3
`endif

// ### common/mfs_pkg.sv
// types for the motor driver fault shutdown block
package mfs_pkg;
  typedef enum logic [1:0] {
    MFS_STANDBY = 2'h0,
    MFS_TWO_PHASE = 2'h1,
    MFS_ONE_TWO_PHASE = 2'h2,
    MFS_W_ONE_TWO_PHASE = 2'h3
  } mfs_mode_t;
endpackage : mfs_pkg

// ### logic/mfs_fault_shutdown.sv
// fault shutdown logic for a two-phase stepping motor driver
`timescale 1ns/10ps
`default_nettype none
`include "mfs_consts.svh"

// ================================================================
// per-phase overcurrent qualifier
// counts oscillator ticks while the detector stays high; any gap restarts
// the count, so chopper switching spikes never reach the latch
module mfs_phase_mask #(
  parameter int unsigned MASK_CYCLES = `MFS_MASK_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // qualifying inputs
  input wire logic tick,
  input wire logic hit,
  input wire logic tripped,
  // one-cycle trip request
  output logic trip_now
);
  logic [2:0] mask_cnt;
  logic [2:0] next_mask_cnt;

  always_comb begin
    next_mask_cnt = mask_cnt;
    trip_now = 1'b0;
    if (!hit) begin
      next_mask_cnt = 3'h0;
    end else if (tick && !tripped) begin
      if (mask_cnt >= 3'(MASK_CYCLES - 1)) begin
        trip_now = 1'b1;
        next_mask_cnt = 3'h0;
      end else begin
        next_mask_cnt = mask_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mask_cnt <= 3'h0;
    end else begin
      mask_cnt <= next_mask_cnt;
    end
  end
endmodule : mfs_phase_mask

// ================================================================
// fault shutdown top
module mfs_fault_shutdown #(
  parameter int unsigned MASK_CYCLES = `MFS_MASK_CYCLES,
  parameter int unsigned EXIT_CYCLES = `MFS_EXIT_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // chopper oscillator tick, one cycle per oscillator period
  input wire logic chopper_oscillator,
  // host mode select pins
  input wire logic mode_1,
  input wire logic mode_2,
  // analog detectors
  input wire logic thermal_hot,
  input wire logic [1:0] overcurrent_hit,
  input wire logic vm_low,
  input wire logic vcc_low,
  // results
  output var mfs_pkg::mfs_mode_t mode,
  output logic oscillator_enable,
  output logic [1:0] phase_enable,
  output logic thermal_trip_latch,
  output logic [1:0] overcurrent_trip_latch
);
  import mfs_pkg::*;

  // ================================================================
  // overcurrent masking, one qualifier per phase
  logic [1:0] trip_now;

  mfs_phase_mask #(
    .MASK_CYCLES(MASK_CYCLES)
  ) u_mask_a (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tick(chopper_oscillator),
    .hit(overcurrent_hit[0]),
    .tripped(overcurrent_trip_latch[0]),
    .trip_now(trip_now[0])
  );

  mfs_phase_mask #(
    .MASK_CYCLES(MASK_CYCLES)
  ) u_mask_b (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tick(chopper_oscillator),
    .hit(overcurrent_hit[1]),
    .tripped(overcurrent_trip_latch[1]),
    .trip_now(trip_now[1])
  );

  // ================================================================
  // thermal latch
  logic standby_req;
  logic next_thermal;

  always_comb begin
    standby_req = ({mode_1, mode_2} == `MFS_MODE_STANDBY);
    next_thermal = thermal_trip_latch;
    if (standby_req) begin
      next_thermal = 1'b0;
    end
    // a part still hot in the clearing cycle stays tripped
    if (thermal_hot) begin
      next_thermal = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      thermal_trip_latch <= 1'b0;
    end else begin
      thermal_trip_latch <= next_thermal;
    end
  end

  // ================================================================
  // overcurrent latches and exit pacing
  logic [2:0] exit_cnt;
  logic [2:0] next_exit_cnt;
  logic [1:0] next_oc;
  logic clearing;

  always_comb begin
    next_oc = overcurrent_trip_latch;
    next_exit_cnt = exit_cnt;
    clearing = 1'b0;
    // exit is paced by the oscillator tick so release lands within the bound
    if (standby_req && (overcurrent_trip_latch != 2'h0)) begin
      if (chopper_oscillator) begin
        next_exit_cnt = exit_cnt + 3'h1;
      end
      if (next_exit_cnt >= 3'(EXIT_CYCLES) || exit_cnt >= 3'(EXIT_CYCLES - 1)) begin
        clearing = 1'b1;
      end
    end else begin
      next_exit_cnt = 3'h0;
    end
    // per-phase latches are kept so the host can tell which bridge tripped
    for (int p = 0; p < 2; p++) begin
      if (clearing) begin
        next_oc[p] = 1'b0;
      end
      if (trip_now[p]) begin
        next_oc[p] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      overcurrent_trip_latch <= 2'h0;
      exit_cnt <= 3'h0;
    end else begin
      overcurrent_trip_latch <= next_oc;
      exit_cnt <= next_exit_cnt;
    end
  end

  // ================================================================
  // output gating
  mfs_mode_t next_mode;
  logic next_osc_en;
  logic [1:0] next_phase_en;
  logic supply_bad;

  always_comb begin
    supply_bad = vm_low || vcc_low;
    next_mode = mfs_mode_t'({mode_1, mode_2});
    // any latched overcurrent puts the part in standby until cleared
    if (next_oc != 2'h0) begin
      next_mode = MFS_STANDBY;
    end
    next_osc_en = (next_mode != MFS_STANDBY);
    next_phase_en = {2{next_osc_en}} & ~next_oc;
    if (next_thermal || supply_bad) begin
      next_phase_en = 2'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode <= MFS_STANDBY;
      oscillator_enable <= 1'b0;
      phase_enable <= 2'h0;
    end else begin
      mode <= next_mode;
      oscillator_enable <= next_osc_en;
      phase_enable <= next_phase_en;
    end
  end
endmodule : mfs_fault_shutdown
`default_nettype wire

// ### testbench/mfs_assertions.sv
// port checker for the fault shutdown block
`timescale 1ns/10ps
`default_nettype none
module mfs_checker (
  input wire logic sys_clk, resetn, chopper_oscillator, mode_1, mode_2, thermal_hot,
  input wire logic [1:0] overcurrent_hit,
  input wire logic vm_low, vcc_low, oscillator_enable, thermal_trip_latch,
  input wire mfs_pkg::mfs_mode_t mode,
  input wire logic [1:0] phase_enable, overcurrent_trip_latch
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic stby = !mode_1 && !mode_2;
  wire logic oc = |overcurrent_trip_latch;
  // =============================
  // shutdown paths
  AST_HOT: assert property (thermal_hot |=> thermal_trip_latch && phase_enable == 2'h0)
    else $error("thermal trip missed");
  AST_HOLD: assert property (thermal_trip_latch && !stby |=> thermal_trip_latch)
    else $error("thermal latch dropped");
  AST_OCOFF: assert property (oc |-> phase_enable == 2'h0)
    else $error("outputs on during trip");
  AST_OCA: assert property ($rose(overcurrent_trip_latch[0]) |-> $past(overcurrent_hit[0]))
    else $error("phase a trip without cause");
  AST_OCB: assert property ($rose(overcurrent_trip_latch[1]) |-> $past(overcurrent_hit[1]))
    else $error("phase b trip without cause");
  AST_OCKEEP: assert property (oc && !stby |=> (overcurrent_trip_latch & $past(overcurrent_trip_latch)) == $past(overcurrent_trip_latch))
    else $error("overcurrent latch dropped");
  AST_OCSTBY: assert property (oc |-> mode == 2'h0 && !oscillator_enable)
    else $error("trip not in standby");
  AST_STBY: assert property (stby |=> !oscillator_enable && phase_enable == 2'h0)
    else $error("standby decode wrong");
  AST_SUPPLY: assert property (vm_low || vcc_low |=> phase_enable == 2'h0)
    else $error("low supply left outputs on");
endmodule : mfs_checker
bind mfs_fault_shutdown mfs_checker u_chk (.*);
`default_nettype wire

// ### testbench/mfs_host_model.sv
// host model driving the mode select pins
`timescale 1ns/10ps
`default_nettype none
module mfs_host_model (
  input wire logic resetn,
  input wire logic stby,
  input wire logic [1:0] sel,
  output logic mode_1,
  output logic mode_2
);
  // pins sit in standby until power is good
  always_comb {mode_1, mode_2} = (!resetn || stby) ? 2'h0 : sel;
endmodule : mfs_host_model
`default_nettype wire

// ### testbench/testbench.sv
// random bench with a reference model of the fault latches
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, x, g) begin num_checks++; if ((g) !== (x)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", n, x, g); end end
module testbench;
  import mfs_pkg::*;
  logic sys_clk = 0, resetn = 0, tick = 0, hot = 0, vm = 0, vcc = 0, stby = 1, n;
  logic m1, m2, osc, thl, th = 0;
  logic [1:0] hit = 0, sel = 1, pe, ocl, oc = 0, x_pe = 0, x_mode = 0, q;
  mfs_mode_t mode;
  int err_total = 0, num_checks = 0, e = 0, c[2] = '{0, 0};
  bit s, k;
  always #2 sys_clk = ~sys_clk;
  mfs_host_model host (.resetn, .stby, .sel, .mode_1(m1), .mode_2(m2));
  mfs_fault_shutdown dut (.sys_clk, .resetn, .chopper_oscillator(tick), .mode_1(m1),
    .mode_2(m2), .thermal_hot(hot), .overcurrent_hit(hit), .vm_low(vm), .vcc_low(vcc),
    .mode, .oscillator_enable(osc), .phase_enable(pe), .thermal_trip_latch(thl),
    .overcurrent_trip_latch(ocl));
  // =============================
  // reference model, updated on the same edge the design samples
  always @(posedge sys_clk) if (resetn) begin
    s = !m1 && !m2;
    th = hot ? 1'b1 : (s ? 1'b0 : th);
    // release comes one edge after the third standby tick, from latches before this edge
    q = oc;
    k = s && q != 2'h0 && e >= 3;
    e = (s && q != 2'h0) ? e + int'(tick) : 0;
    if (k) oc = 2'h0;
    for (int p = 0; p < 2; p++) begin
      c[p] = !hit[p] ? 0 : c[p] + int'(tick && !q[p]);
      if (c[p] == 4) begin
        oc[p] = 1'b1;
        c[p] = 0;
      end
    end
    x_pe = (th || vm || vcc || s || oc != 2'h0) ? 2'h0 : 2'h3;
    x_mode = (oc != 2'h0) ? 2'h0 : {m1, m2};
  end
  always @(negedge sys_clk) if (resetn) begin
    `CHK("thermal", th, thl)
    `CHK("overcurrent", oc, ocl)
    `CHK("phase_enable", x_pe, pe)
    `CHK("mode", x_mode, 2'(mode))
    `CHK("osc", x_mode != 2'h0, osc)
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
  initial begin
    void'($urandom(44));
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (5000) begin
      @(posedge sys_clk);
      // no overcurrent while the host parks the pins in standby
      n = stby ^ ($urandom % 40 == 0);
      stby <= n;
      if (n != stby) sel <= 2'(1 + $urandom % 3);
      tick <= $urandom % 3 == 0;
      hot <= $urandom % 300 == 0;
      vm <= $urandom % 150 == 0;
      vcc <= $urandom % 150 == 0;
      hit <= n ? 2'h0 : (($urandom % 24 == 0) ? 2'($urandom) : hit);
    end
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
